/* shared/dlasi_consts.svh */
// Constants for the dual line alarm status and interrupt block
`ifndef DLASI_CONSTS_SVH
`define DLASI_CONSTS_SVH
`define DLASI_CH1_ADDR   8'h10
`define DLASI_CH2_ADDR   8'h11
`define DLASI_PAR_CH1    4'h0
`define DLASI_PAR_CH2    4'h1
`define DLASI_BIT_LIVE_ABS 7
`define DLASI_BIT_LAT_ABS  6
`define DLASI_BIT_LIVE_ALM 5
`define DLASI_BIT_LAT_ALM  4
`define DLASI_BIT_LAT_CV   3
`define DLASI_BIT_LAT_OVF  2
`define DLASI_BIT_LAT_AUX  1
`define DLASI_BIT_CHG      0
`define DLASI_CH1_LAT_RST  8'h43
`define DLASI_CH2_LAT_RST  8'h41
`define DLASI_LIVE_ABS_RST 1'h1
`define DLASI_LIVE_ALM_RST 1'h0
`define DLASI_RD_RST       8'h00
`define DLASI_IRQ_RST      1'h1
`endif

/* shared/dlasi_pkg.sv */
// Types for the dual line alarm status and interrupt block
`default_nettype none
package dlasi_pkg;
	// Condition inputs of one channel
	typedef struct packed {
		logic absent;
		logic alarm;
		logic violation;
		logic overflow;
		logic aux_event;
		logic decoder_en;
		logic sleep;
	} dlasi_chan_s;
	typedef logic [7:0] dlasi_byte_t;
endpackage
`default_nettype wire

/* hdl/dlasi_top.sv */
// Status registers and interrupt output of the dual line interface
`timescale 1ns/1ps
`default_nettype none
`include "dlasi_consts.svh"

module dlasi_top (
	input  wire logic                        clk_i,
	input  wire logic                        rstn_i,
	input  wire dlasi_pkg::dlasi_chan_s [1:0] chan_i,
	input  wire logic [1:0][7:0]             mask_i,
	input  wire logic                        bus_style_select_i,
	input  wire logic                        irq_level_select_i,
	input  wire logic                        parallel_mode_i,
	input  wire logic [3:0]                  board_slot_addr_i,
	input  wire logic [7:0]                  addr_i,
	input  wire logic                        rd_i,
	output logic [7:0]                       rd_data_o,
	output logic                             irq_o
);
	import dlasi_pkg::*;

	// One clock domain; checks are off while reset is held
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	// Address decode for one channel, serial or parallel form
	function automatic logic chan_hit(input logic par, input logic [3:0] slot,
			input logic [7:0] a, input logic [7:0] ser, input logic [3:0] low);
		chan_hit = par ? (a[7:4] == slot && a[3:0] == low) : (a == ser);
	endfunction

	logic [1:0]            rd_hit_w;
	logic [1:0]            pend_w;
	logic [1:0][7:0]       stat_w;
	logic [1:0][7:0]       set_w;
	logic [1:0][7:0]       meff_w;
	logic [1:0][7:0]       hold_w;
	logic [1:0][7:0]       lat_q;
	logic [1:0][7:0]       lat_d;
	logic [1:0]            abs_q;
	logic [1:0]            alm_q;
	logic [1:0]            change_w;
	logic                  act_w;
	logic                  irq_d;
	dlasi_byte_t           rd_data_q;
	dlasi_byte_t           rd_data_d;
	logic                  irq_q;

	// Read strobes; status has no write path at all
	// read only registers
	assign rd_hit_w[0] = rd_i & chan_hit(parallel_mode_i, board_slot_addr_i, addr_i,
		`DLASI_CH1_ADDR, `DLASI_PAR_CH1);
	assign rd_hit_w[1] = rd_i & chan_hit(parallel_mode_i, board_slot_addr_i, addr_i,
		`DLASI_CH2_ADDR, `DLASI_PAR_CH2);

	// Per channel event detection and latching
	for (genvar g = 0; g < 2; g++) begin : g_chan
		localparam logic [7:0] LAT_RST = (g == 0) ? `DLASI_CH1_LAT_RST : `DLASI_CH2_LAT_RST;
		logic rise_abs;
		logic fall_abs;
		logic rise_alm;
		logic fall_alm;
		logic set0;
		logic keep0;

		// Channel one bit 1 is never masked; channel two takes its mask unchanged
		// unmaskable reset bit
		assign meff_w[g] = (g == 0) ? (mask_i[g] & 8'hFD) : mask_i[g];

		// Change bit survives its mask while the reset event is latched
		// reset event interrupts
		assign keep0 = (g == 0) & (lat_q[g][`DLASI_BIT_LAT_AUX]
			| set_w[g][`DLASI_BIT_LAT_AUX]);
		assign hold_w[g] = meff_w[g] & ~{7'h00, keep0};

		assign rise_abs = chan_i[g].absent & ~abs_q[g];
		assign fall_abs = ~chan_i[g].absent & abs_q[g];
		assign rise_alm = chan_i[g].alarm & ~alm_q[g];
		assign fall_alm = ~chan_i[g].alarm & alm_q[g];

		// Latch set terms, each gated by its mask bit
		// absence start latch
		assign set_w[g][`DLASI_BIT_LAT_ABS] = rise_abs & ~meff_w[g][`DLASI_BIT_LAT_ABS];
		assign set_w[g][`DLASI_BIT_LAT_ALM] = rise_alm & ~meff_w[g][`DLASI_BIT_LAT_ALM];
		assign set_w[g][`DLASI_BIT_LAT_CV] = chan_i[g].violation & chan_i[g].decoder_en
			& ~meff_w[g][`DLASI_BIT_LAT_CV];
		assign set_w[g][`DLASI_BIT_LAT_OVF] = chan_i[g].overflow
			& ~meff_w[g][`DLASI_BIT_LAT_OVF];
		assign set_w[g][`DLASI_BIT_LAT_AUX] = chan_i[g].aux_event
			& ~meff_w[g][`DLASI_BIT_LAT_AUX];
		assign set_w[g][`DLASI_BIT_LIVE_ABS] = 1'b0;
		assign set_w[g][`DLASI_BIT_LIVE_ALM] = 1'b0;

		// Changes that count: live bits only on condition end
		// live absence end only
		assign change_w[g] = (fall_abs & ~meff_w[g][`DLASI_BIT_LIVE_ABS])
			| (fall_alm & ~meff_w[g][`DLASI_BIT_LIVE_ALM])
			| (|set_w[g][7:1]);

		// Channel one's reset event bypasses the change mask so it interrupts unless sleep is held
		// change record bit
		assign set0 = (change_w[g] & ~meff_w[g][`DLASI_BIT_CHG])
			| ((g == 0) & set_w[g][`DLASI_BIT_LAT_AUX]);
		assign set_w[g][`DLASI_BIT_CHG] = set0;

		// Set wins over the read clear; mask holds the bit at zero
		// set beats clear
		assign lat_d[g] = chan_i[g].sleep ? (LAT_RST & ~meff_w[g])
			: (((lat_q[g] & {8{~rd_hit_w[g]}}) | set_w[g]) & ~hold_w[g]);

		// Visible status byte
		// live absence bit
		assign stat_w[g] = {abs_q[g], lat_q[g][6], alm_q[g], lat_q[g][4:0]} & ~hold_w[g];
		assign pend_w[g] = lat_q[g][`DLASI_BIT_CHG];

		// Status state; live copies also feed the edge detectors
		// reset values
		always_ff @(posedge clk_i) begin
			if (!rstn_i) begin
				lat_q[g] <= LAT_RST;
				abs_q[g] <= `DLASI_LIVE_ABS_RST;
				alm_q[g] <= `DLASI_LIVE_ALM_RST;
			end else begin
				lat_q[g] <= lat_d[g];
				abs_q[g] <= chan_i[g].absent;
				alm_q[g] <= chan_i[g].alarm;
			end
		end

		a_live_abs_follow: assert property (
			stat_w[g][7] == ($past(chan_i[g].absent) && !meff_w[g][7]))
			else $error("live absence bit wrong");
		a_abs_end_change: assert property (
			fall_abs && !meff_w[g][7] && !meff_w[g][0] && !chan_i[g].sleep
			|=> lat_q[g][0])
			else $error("absence end not recorded");
		a_abs_start_latch: assert property (
			rise_abs && !meff_w[g][6] && !chan_i[g].sleep |=> lat_q[g][6])
			else $error("absence start not latched");
		a_alm_end_change: assert property (
			fall_alm && !meff_w[g][5] && !meff_w[g][0] && !chan_i[g].sleep
			|=> lat_q[g][0])
			else $error("alarm end not recorded");
		a_alm_start_latch: assert property (
			rise_alm && !meff_w[g][4] && !chan_i[g].sleep |=> lat_q[g][4])
			else $error("alarm start not latched");
		a_cv_decoder_gate: assert property (
			!chan_i[g].decoder_en && !lat_q[g][3] |=> !lat_q[g][3])
			else $error("violation latched with decoder off");
		a_ovf_latch: assert property (
			chan_i[g].overflow && !meff_w[g][2] && !chan_i[g].sleep
			|=> lat_q[g][2])
			else $error("overflow not latched");
		a_aux_latch: assert property (
			chan_i[g].aux_event && !meff_w[g][1] && !chan_i[g].sleep
			|=> lat_q[g][1])
			else $error("bit one event not latched");
		a_chg_clear: assert property (
			rd_hit_w[g] && !change_w[g] && !chan_i[g].sleep
			&& !((g == 0) && set_w[g][1]) |=> !lat_q[g][0])
			else $error("change bit not cleared by read");
		a_mask_zero: assert property (
			(stat_w[g] & hold_w[g]) == 8'h00)
			else $error("masked bit not zero");
		a_sleep_reset: assert property (
			chan_i[g].sleep |=> lat_q[g] == (LAT_RST & ~$past(meff_w[g])))
			else $error("sleep did not reset status");
		a_set_over_clear: assert property (
			rd_hit_w[g] && set_w[g][2] && !chan_i[g].sleep |=> lat_q[g][2])
			else $error("event lost under clearing read");
		a_reset_values: assert property (
			$past(!rstn_i) |-> lat_q[g] == LAT_RST && abs_q[g] && !alm_q[g])
			else $error("reset values wrong");
		a_abs_read_clear: assert property (
			rd_hit_w[g] && !rise_abs && !chan_i[g].sleep |=> !lat_q[g][6])
			else $error("absence latch not cleared by read");
		a_live_alm_follow: assert property (
			stat_w[g][5] == ($past(chan_i[g].alarm) && !meff_w[g][5]))
			else $error("live alarm bit wrong");
		a_alm_read_clear: assert property (
			rd_hit_w[g] && !rise_alm && !chan_i[g].sleep |=> !lat_q[g][4])
			else $error("alarm latch not cleared by read");
		a_cv_latch: assert property (
			chan_i[g].violation && chan_i[g].decoder_en && !meff_w[g][3]
			&& !chan_i[g].sleep |=> lat_q[g][3])
			else $error("violation not latched");
		a_ovf_read_clear: assert property (
			rd_hit_w[g] && !chan_i[g].overflow && !chan_i[g].sleep |=> !lat_q[g][2])
			else $error("overflow latch not cleared by read");
		a_aux_read_clear: assert property (
			rd_hit_w[g] && !chan_i[g].aux_event && !chan_i[g].sleep |=> !lat_q[g][1])
			else $error("bit one latch not cleared by read");
		a_chg_set: assert property (
			(|set_w[g][7:1]) && !meff_w[g][0] && !chan_i[g].sleep |=> lat_q[g][0])
			else $error("change not recorded");
		a_mask_latched: assert property (
			$past(rstn_i) |-> (lat_q[g] & $past(hold_w[g])) == 8'h00)
			else $error("masked latch bit set");
	end

	// Active level of the interrupt pin
	// level from select input
	assign act_w = bus_style_select_i ? 1'b0 : irq_level_select_i;

	// Interrupt stays active until both change bits are read away
	// unmasked change interrupts
	assign irq_d = (|pend_w) ? act_w : ~act_w;

	// Read data mux; a miss keeps the last byte
	assign rd_data_d = rd_hit_w[0] ? stat_w[0] : (rd_hit_w[1] ? stat_w[1] : rd_data_q);

	// Output flops
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rd_data_q <= `DLASI_RD_RST;
			irq_q     <= `DLASI_IRQ_RST;
		end else begin
			rd_data_q <= rd_data_d;
			irq_q     <= irq_d;
		end
	end

	assign rd_data_o = rd_data_q;
	assign irq_o     = irq_q;

	sequence s_change_seen;
		change_w[0] && !meff_w[0][0] && !chan_i[0].sleep;
	endsequence

	a_change_irq: assert property (
		s_change_seen ##1 !bus_style_select_i ##1 1'b1 |-> irq_o == $past(act_w))
		else $error("change did not raise interrupt");
	a_irq_level: assert property (
		|pend_w && !bus_style_select_i |=> irq_o == $past(irq_level_select_i))
		else $error("interrupt level wrong");
	a_irq_low: assert property (
		|pend_w && bus_style_select_i |=> !irq_o)
		else $error("interrupt not active low");
	a_irq_idle: assert property (
		pend_w == 2'b00 |=> irq_o == !$past(act_w))
		else $error("interrupt active with nothing pending");
	a_reset_unmasked: assert property (
		chan_i[0].aux_event && !chan_i[0].sleep |=> lat_q[0][1] && lat_q[0][0])
		else $error("reset event masked");
	a_decode_excl: assert property (
		!(rd_hit_w[0] && rd_hit_w[1]))
		else $error("both channels decoded");
	a_read_data: assert property (
		rd_hit_w[1] |=> rd_data_o == $past(stat_w[1]))
		else $error("read data wrong");
	a_slot_match: assert property (
		parallel_mode_i && addr_i[7:4] != board_slot_addr_i |-> rd_hit_w == 2'b00)
		else $error("slot mismatch decoded");

	a_reset_outputs: assert property (
		$past(!rstn_i) |-> rd_data_o == `DLASI_RD_RST && irq_o == `DLASI_IRQ_RST)
		else $error("outputs wrong after reset");
	a_miss_holds: assert property (
		rd_hit_w == 2'b00 |=> $stable(rd_data_o))
		else $error("read data changed without a read");

	// No new change and no sleep in either channel
	sequence s_quiet;
		!set_w[0][`DLASI_BIT_CHG] && !set_w[1][`DLASI_BIT_CHG]
		&& !chan_i[0].sleep && !chan_i[1].sleep;
	endsequence

	// Channel one read, then channel two read two cycles on
	sequence s_both_read;
		rd_hit_w[0] ##0 s_quiet ##1 s_quiet ##1 rd_hit_w[1] ##0 s_quiet;
	endsequence

	a_both_read_idle: assert property (
		s_both_read |=> ##1 irq_o == !$past(act_w))
		else $error("interrupt still active after both reads");
endmodule
`default_nettype wire

/* tb/dlasi_host.sv */
// Host processor model issuing status register reads
`timescale 1ns/1ps
`default_nettype none
module dlasi_host (
	input  wire logic clk_i,
	output logic [7:0] addr_o,
	output logic       rd_o
);
	initial begin
		addr_o = 8'h00;
		rd_o   = 1'b0;
	end
	// reads only
	// Strobe and address held across the taking edge
	task automatic read(input logic [7:0] a);
		@(negedge clk_i);
		addr_o = a;
		rd_o   = 1'b1;
		@(negedge clk_i);
		rd_o   = 1'b0;
		addr_o = ~a; // Released bus must not keep the old address
	endtask
endmodule
`default_nettype wire

/* tb/dlasi_top_tb.sv */
// Self-checking bench for the alarm status and interrupt block
`timescale 1ns/1ps
`default_nettype none
module dlasi_top_tb;
	import dlasi_pkg::*;
	localparam logic [6:0] VIOL = 7'h10;
	localparam logic [6:0] OVF  = 7'h08;
	localparam logic [6:0] AUX  = 7'h04;
	logic              clk_i  = 1'b0;
	logic              rstn_i = 1'b0;
	dlasi_chan_s [1:0] chan;
	logic [1:0][7:0]   mask;
	logic              style  = 1'b0;
	logic              lvl    = 1'b0;
	logic              par    = 1'b0;
	logic [3:0]        slot   = 4'h0;
	logic [7:0]        addr;
	logic              rd;
	dlasi_byte_t       rd_data;
	logic              irq;
	logic              taken  = 1'b0;
	dlasi_byte_t       exp_q[$];
	dlasi_byte_t       last   = 8'h00;
	int                num_errors = 0;
	int                checked    = 0;

	dlasi_top dlasi_top_i (
		.clk_i              (clk_i),
		.rstn_i             (rstn_i),
		.chan_i             (chan),
		.mask_i             (mask),
		.bus_style_select_i (style),
		.irq_level_select_i (lvl),
		.parallel_mode_i    (par),
		.board_slot_addr_i  (slot),
		.addr_i             (addr),
		.rd_i               (rd),
		.rd_data_o          (rd_data),
		.irq_o              (irq)
	);
	dlasi_host dlasi_host_i (.clk_i(clk_i), .addr_o(addr), .rd_o(rd));

	always #50 clk_i = ~clk_i;

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checked++;
		if (seen !== want) begin
			num_errors++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
		end
	endtask

	task automatic report_and_stop();
		if (num_errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Note the expected byte, then let the host read
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] want);
		exp_q.push_back(want);
		last = want;
		dlasi_host_i.read(a);
	endtask

	// Bounded wait; latency is two edges, four gives margin
	task automatic wait_irq(input logic want);
		for (int n = 0; n < 4 && irq !== want; n++) @(negedge clk_i);
		check({7'h00, irq}, {7'h00, want});
	endtask

	task automatic pulse(input int g, input logic [6:0] f);
		@(negedge clk_i);
		chan[g] = dlasi_chan_s'(chan[g] | f);
		@(negedge clk_i);
		chan[g] = dlasi_chan_s'(chan[g] & ~f);
	endtask

	function automatic logic act();
		return style ? 1'b0 : lvl;
	endfunction

	// Read data lands on the taking edge and is checked one edge after it
	always @(posedge clk_i) taken <= rd;
	always @(negedge clk_i) if (taken) check(rd_data, exp_q.pop_front());

	// Run is about 126 cycles; a 3000 cycle limit, over twenty times that, cuts a hang
	initial begin
		#(3000 * 100);
		num_errors++;
		report_and_stop();
	end

	initial begin
		void'($urandom(32'hb253));
		chan = '0;
		mask = '0;
		chan[0].absent = 1'b1;
		chan[1].absent = 1'b1;
		repeat (3) @(negedge clk_i);
		check({7'h00, irq}, 8'h01);
		rstn_i = 1'b1;
		wait_irq(1'b0);
		rd_reg(8'h10, 8'hC3);
		repeat (2) @(negedge clk_i);
		check({7'h00, irq}, 8'h00);
		rd_reg(8'h11, 8'hC1);
		wait_irq(1'b1);
		rd_reg(8'h10, 8'h80);
		chan[1].absent = 1'b0;
		wait_irq(1'b0);
		rd_reg(8'h11, 8'h01);
		wait_irq(1'b1);
		chan[1].absent = 1'b1;
		wait_irq(1'b0);
		rd_reg(8'h11, 8'hC1);
		rd_reg(8'h11, 8'h80);
		chan[0].alarm = 1'b1;
		wait_irq(1'b0);
		rd_reg(8'h10, 8'hB1);
		rd_reg(8'h10, 8'hA0);
		wait_irq(1'b1);
		chan[0].alarm = 1'b0;
		wait_irq(1'b0);
		rd_reg(8'h10, 8'h81);
		for (int de = 0; de < 2; de++) begin
			chan[0].decoder_en = de[0];
			pulse(0, VIOL);
			repeat (3) @(negedge clk_i);
			rd_reg(8'h10, de[0] ? 8'h89 : 8'h80);
		end
		wait_irq(1'b1);
		// Event lands in the clearing cycle
		fork
			rd_reg(8'h10, 8'h80);
			pulse(0, OVF);
		join
		wait_irq(1'b0);
		rd_reg(8'h10, 8'h85);
		wait_irq(1'b1);
		mask[1] = 8'h02;
		pulse(1, AUX);
		repeat (4) @(negedge clk_i);
		check({7'h00, irq}, 8'h01);
		mask[0] = 8'h7D;
		pulse(0, AUX);
		wait_irq(1'b0);
		rd_reg(8'h10, 8'h83);
		rd_reg(8'h11, 8'h80);
		mask = '0;
		pulse(1, AUX);
		wait_irq(1'b0);
		rd_reg(8'h11, 8'h83);
		wait_irq(1'b1);
		slot = 4'($urandom);
		par = 1'b1;
		pulse(1, OVF);
		wait_irq(1'b0);
		rd_reg({~slot, 4'h1}, last);
		rd_reg({slot, 4'h1}, 8'h85);
		rd_reg({slot, 4'h0}, 8'h80);
		par = 1'b0;
		rd_reg(8'h12, last);
		chan[1].sleep = 1'b1;
		repeat (2) @(negedge clk_i);
		chan[1].sleep = 1'b0;
		wait_irq(1'b0);
		rd_reg(8'h11, 8'hC1);
		rd_reg(8'h10, 8'h80);
		wait_irq(1'b1);
		for (int k = 0; k < 4; k++) begin
			style = k[1];
			lvl = k[0];
			repeat (3) @(negedge clk_i);
			check({7'h00, irq}, {7'h00, ~act()});
			pulse(0, OVF);
			wait_irq(act());
			rd_reg(8'h10, 8'h85);
			wait_irq(~act());
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
